// ---- hdl/basc_drive.v ----
// bridge drive generator: dc or divided square wave
`timescale 1ns/100ps
`include "basc_map.vh"
module basc_drive
(
    input  wire       core_clk_i,
    input  wire       resetn_i,
    input  wire       source_ext_i,
    input  wire [1:0] rate_i,
    input  wire       ext_phase_i,
    output reg        drive_a_o,
    output reg        drive_a_oe_o,
    output reg        drive_b_o,
    output reg        demod_phase_o
);
    reg  [13:0] half_cnt_ff;
    reg         sq_ff;
    wire [13:0] half_lim;

    // half period of the chosen divider, minus one
    assign half_lim = (rate_i == 2'h1) ? 14'd4095 :
                      (rate_i == 2'h2) ? 14'd8191 : 14'd2047;

    // square wave counter; stopped on dc drive
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            half_cnt_ff <= 14'h0000;
            sq_ff       <= 1'b0;
        end
        else if (rate_i == 2'h0)
        begin
            half_cnt_ff <= 14'h0000;
            sq_ff       <= 1'b0;
        end
        else if (half_cnt_ff >= half_lim)
        begin
            half_cnt_ff <= 14'h0000;
            sq_ff       <= ~sq_ff;
        end
        else
        begin
            half_cnt_ff <= half_cnt_ff + 14'h0001;
        end
    end

    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            drive_a_o     <= 1'b0;
            drive_a_oe_o  <= 1'b1;
            drive_b_o     <= 1'b1;
            demod_phase_o <= 1'b0;
        end
        else if (source_ext_i)
        begin
            drive_a_o     <= 1'b0;
            drive_a_oe_o  <= 1'b0;
            drive_b_o     <= ~ext_phase_i;
            demod_phase_o <= ext_phase_i;
        end
        else
        begin
            drive_a_o     <= sq_ff;
            drive_a_oe_o  <= 1'b1;
            drive_b_o     <= ~sq_ff;
            demod_phase_o <= sq_ff;
        end
    end
endmodule // basc_drive

// ---- hdl/basc_map.vh ----
// constants for the bridge converter serial control block
`ifndef BASC_MAP_VH
`define BASC_MAP_VH
// command byte fields
`define BASC_CMD_MARK      7
`define BASC_CMD_SEL_HI    6
`define BASC_CMD_SEL_LO    4
`define BASC_CMD_DIR       3
// register select codes
`define BASC_SEL_CONV      3'h0
`define BASC_SEL_CONFIG    3'h1
`define BASC_SEL_GAIN      3'h2
`define BASC_SEL_DAC       3'h3
`define BASC_SEL_RATIO     3'h4
`define BASC_SEL_SIGNR     3'h5
`define BASC_SEL_REFNR     3'h6
// configuration fields
`define BASC_CFG_SIGN      23
`define BASC_CFG_MAG_HI    22
`define BASC_CFG_MAG_LO    20
`define BASC_CFG_SRC       19
`define BASC_CFG_RATE_HI   18
`define BASC_CFG_RATE_LO   17
`define BASC_CFG_GAIN_HI   15
`define BASC_CFG_GAIN_LO   14
`define BASC_CFG_UNIPOLAR  13
`define BASC_CFG_SLEEP     11
`define BASC_CFG_CAL       10
`define BASC_CFG_CTYPE_HI  7
`define BASC_CFG_CTYPE_LO  4
`define BASC_CFG_FCLEAR    0
// bits that hold a value; the rest read as zero except 23:20, which mirror the offset register
`define BASC_CFG_KEEP      24'h0eecf1
// reset values
`define BASC_CFG_RESET     24'h000000
`define BASC_GAIN_RESET    24'h800000
`define BASC_ZERO_RESET    24'h000000
// drive dividers in master clock cycles
`define BASC_DIV_8192      8192
`define BASC_DIV_16384     16384
`define BASC_DIV_4096      4096
// word lengths
`define BASC_CMD_BITS      8
`define BASC_DATA_BITS     24
// fetch latency of a read word, in core clocks
`define BASC_FETCH_CYC     4
// default calibration length, core clocks
`define BASC_CAL_CYC       573440
`endif

// ---- hdl/basc_sync.v ----
// two flop synchroniser for one pin
`timescale 1ns/100ps
module basc_sync
(
    input  wire core_clk_i,
    input  wire resetn_i,
    input  wire async_i,
    output wire sync_o
);
    reg meta_ff;
    reg sync_ff;
    // first flop only feeds the second
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end
    assign sync_o = sync_ff;
endmodule // basc_sync

// ---- hdl/basc_top.v ----
// serial command interpreter and configuration front end
// Notes on behaviour
// - select field picks one of seven registers
// - direction bit chooses write or read
// - after reset, first eight bits are command
// - valid command switches port to 24-bit data
// - write data may follow command without pause
// - ready goes low once read word fetched
// - chip select release ends conversion read
// - new configuration word is decoded and executed
// - top four configuration bits mirror offset register
// - magnitude code gives 25 to 175 percent
// - source bit picks internal or external drive
// - rate field gives dc or divided square
// - bit thirteen picks bipolar or unipolar
// - calibration bit starts calibration of chosen type
// - calibration type field selects target
// - bit zero clears the digital filter
// - reset: ready high, config zero, gain mid
// - latch on 24th falling edge, recalibrate
// - ready high during calibration, low after
`timescale 1ns/100ps
`include "basc_map.vh"
module basc_top
#(
    parameter CAL_CYCLES = `BASC_CAL_CYC
)
(
    input  wire        core_clk_i,
    input  wire        resetn_i,
    input  wire        serial_clk_i,
    input  wire        chip_select_n_i,
    input  wire        serial_in_i,
    output reg         serial_out_o,
    output reg         serial_out_oe_o,
    output reg         data_ready_n_o,
    input  wire [23:0] conv_data_i,
    input  wire        conv_valid_i,
    input  wire        bridge_drive_a_i,
    output wire        bridge_drive_a_o,
    output wire        bridge_drive_a_oe_o,
    output wire        bridge_drive_b_o,
    output wire        demod_phase_o,
    output reg  [2:0]  offset_magnitude_o,
    output reg         offset_sign_o,
    output reg  [3:0]  gain_factor_o,
    output reg         unipolar_o,
    output reg         sleep_o,
    output reg         filter_clear_o,
    output reg         cal_busy_o,
    output reg  [3:0]  cal_target_o
);
    ////////////////////////////////////////////////////////////////////
    // port states, one hot
    localparam [4:0] ST_CMD   = 5'h01;
    localparam [4:0] ST_WR    = 5'h02;
    localparam [4:0] ST_FETCH = 5'h04;
    localparam [4:0] ST_RD    = 5'h08;
    localparam [4:0] ST_CAL   = 5'h10;

    reg  [4:0]  state_ff;
    reg  [4:0]  nxt_state;
    reg  [7:0]  cmd_ff;
    reg  [4:0]  bit_cnt_ff;
    reg  [23:0] shift_ff;
    reg  [23:0] cfg_ff;
    reg  [23:0] gain_ff;
    reg  [23:0] dac_ff;
    reg  [23:0] ratio_ff;
    reg  [23:0] signr_ff;
    reg  [23:0] refnr_ff;
    reg  [23:0] conv_ff;
    reg  [31:0] wait_cnt_ff;
    reg         sclk_d_ff;
    wire        sclk_s;
    wire        csn_s;
    wire        sdi_s;
    wire        ext_s;
    wire        rise;
    wire        fall;
    wire        active;
    wire [7:0]  cmd_next;
    wire        last_cmd_bit;
    wire        last_data_bit;
    wire [23:0] cfg_written;

    ////////////////////////////////////////////////////////////////////
    // every pin from the host is synchronised before use
    basc_sync u_sync [3:0]
    (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .async_i    ({bridge_drive_a_i, serial_in_i, ~chip_select_n_i,
                      serial_clk_i}),
        .sync_o     ({ext_s, sdi_s, csn_s, sclk_s})
    );

    // sclk edge detect on the synchronised copy
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            sclk_d_ff <= 1'b0;
        else
            sclk_d_ff <= sclk_s;
    end
    assign active = csn_s;
    assign rise   = active & sclk_s & ~sclk_d_ff;
    assign fall   = active & ~sclk_s & sclk_d_ff;

    ////////////////////////////////////////////////////////////////////
    // a command is valid when marked, low bits are clear and select is not seven
    function cmd_valid;
        input [7:0] c;
        begin
            cmd_valid = c[`BASC_CMD_MARK] & (c[2:0] == 3'h0) &
                        (c[6:4] != 3'h7);
        end
    endfunction

    // read mux over the register file
    function [23:0] reg_pick;
        input [2:0]  sel;
        begin
            case (sel)
                `BASC_SEL_CONV:   reg_pick = conv_ff;
                `BASC_SEL_CONFIG: reg_pick = cfg_ff;
                `BASC_SEL_GAIN:   reg_pick = gain_ff;
                `BASC_SEL_DAC:    reg_pick = dac_ff;
                `BASC_SEL_RATIO:  reg_pick = ratio_ff;
                `BASC_SEL_SIGNR:  reg_pick = signr_ff;
                `BASC_SEL_REFNR:  reg_pick = refnr_ff;
                default:          reg_pick = 24'h000000;
            endcase
        end
    endfunction

    assign cmd_next      = {cmd_ff[6:0], sdi_s};
    assign last_cmd_bit  = (bit_cnt_ff == 5'd7);
    assign last_data_bit = (bit_cnt_ff == 5'd23);
    // sign and magnitude track the offset register
    assign cfg_written   = {dac_ff[23:20], 20'h00000} |
                           (shift_ff & `BASC_CFG_KEEP);

    ////////////////////////////////////////////////////////////////////
    // port sequencer
    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            // first eight bits form the command
            ST_CMD:
            begin
                if (rise && last_cmd_bit && cmd_valid(cmd_next))
                begin
                    // write data taken with no pause
                    if (cmd_next[`BASC_CMD_DIR])
                        nxt_state = ST_FETCH;
                    else
                        nxt_state = ST_WR;
                end
            end
            ST_WR:
            begin
                if (fall && bit_cnt_ff == 5'h18)
                begin
                    // a config write acts on its own request bit
                    if ((cmd_ff[6:4] == `BASC_SEL_CONFIG) ?
                        shift_ff[`BASC_CFG_CAL] : cfg_ff[`BASC_CFG_CAL])
                        nxt_state = ST_CAL;
                    else
                        nxt_state = ST_CMD;
                end
            end
            ST_FETCH:
            begin
                if (wait_cnt_ff == `BASC_FETCH_CYC - 1)
                    nxt_state = ST_RD;
            end
            ST_RD:
            begin
                // chip select release ends the read
                if (!active)
                    nxt_state = ST_CMD;
                else if (fall && last_data_bit)
                    nxt_state = ST_CMD;
            end
            ST_CAL:
            begin
                if (wait_cnt_ff == CAL_CYCLES - 1)
                    nxt_state = ST_CMD;
            end
            default: nxt_state = ST_CMD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state, counters and shifting
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_ff    <= ST_CMD;
            cmd_ff      <= 8'h00;
            bit_cnt_ff  <= 5'h00;
            shift_ff    <= 24'h000000;
            wait_cnt_ff <= 32'h00000000;
        end
        else
        begin
            state_ff <= nxt_state;
            if (nxt_state != state_ff)
                bit_cnt_ff <= 5'h00;
            else if (state_ff == ST_CMD && rise && last_cmd_bit)
                bit_cnt_ff <= 5'h00; // refused byte: next byte starts
            else if ((state_ff == ST_CMD || state_ff == ST_WR) && rise)
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
            else if (state_ff == ST_RD && fall)
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
            // unframed bits restart the command count
            if (state_ff == ST_CMD && !active)
                bit_cnt_ff <= 5'h00;
            if (state_ff == ST_CMD && rise)
                cmd_ff <= cmd_next;
            if (state_ff == ST_WR && rise)
                shift_ff <= {shift_ff[22:0], sdi_s};
            else if (state_ff == ST_FETCH && nxt_state == ST_RD)
                shift_ff <= reg_pick(cmd_ff[6:4]);
            else if (state_ff == ST_RD && fall)
                shift_ff <= {shift_ff[22:0], 1'b0};
            if (nxt_state != state_ff)
                wait_cnt_ff <= 32'h00000000;
            else
                wait_cnt_ff <= wait_cnt_ff + 32'h00000001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register file; writes land at the 24th falling edge
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cfg_ff   <= `BASC_CFG_RESET;
            gain_ff  <= `BASC_GAIN_RESET;
            dac_ff   <= `BASC_ZERO_RESET;
            ratio_ff <= `BASC_ZERO_RESET;
            signr_ff <= `BASC_ZERO_RESET;
            refnr_ff <= `BASC_ZERO_RESET;
            conv_ff  <= `BASC_ZERO_RESET;
        end
        else
        begin
            // conversion word frozen while the host reads it
            if (conv_valid_i && state_ff != ST_RD)
                conv_ff <= conv_data_i;
            if (state_ff == ST_WR && fall && bit_cnt_ff == 5'h18)
            begin
                case (cmd_ff[6:4])
                    `BASC_SEL_CONFIG: cfg_ff   <= cfg_written;
                    `BASC_SEL_GAIN:   gain_ff  <= shift_ff;
                    `BASC_SEL_DAC:    dac_ff   <= shift_ff;
                    `BASC_SEL_RATIO:  ratio_ff <= shift_ff;
                    `BASC_SEL_SIGNR:  signr_ff <= shift_ff;
                    `BASC_SEL_REFNR:  refnr_ff <= shift_ff;
                    default:          cfg_ff   <= cfg_ff;
                endcase
            end
            else if (cfg_ff[23:20] != dac_ff[23:20])
                cfg_ff[23:20] <= dac_ff[23:20];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // serial output and ready pin
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            serial_out_o    <= 1'b0;
            serial_out_oe_o <= 1'b0;
            data_ready_n_o  <= 1'b1;
        end
        else
        begin
            serial_out_o    <= shift_ff[23];
            serial_out_oe_o <= (state_ff == ST_RD) & (nxt_state == ST_RD);
            // ready low once word is placed
            // high during calibration, low at end
            if (state_ff == ST_FETCH && nxt_state == ST_RD)
                data_ready_n_o <= 1'b0;
            else if (nxt_state == ST_CAL)
                data_ready_n_o <= 1'b1;
            else if (state_ff == ST_CAL)
                data_ready_n_o <= 1'b0;
            else if (state_ff == ST_RD && nxt_state == ST_CMD)
                data_ready_n_o <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decoded configuration outputs
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            offset_magnitude_o <= 3'h0;
            offset_sign_o      <= 1'b0;
            gain_factor_o      <= 4'h1;
            unipolar_o         <= 1'b0;
            sleep_o            <= 1'b0;
            filter_clear_o     <= 1'b0;
            cal_busy_o         <= 1'b0;
            cal_target_o       <= 4'h0;
        end
        else
        begin
            offset_magnitude_o <= cfg_ff[22:20];
            offset_sign_o      <= cfg_ff[`BASC_CFG_SIGN];
            case (cfg_ff[15:14])
                2'h0:    gain_factor_o <= 4'h1;
                2'h2:    gain_factor_o <= 4'h2;
                2'h1:    gain_factor_o <= 4'h4;
                default: gain_factor_o <= 4'h8;
            endcase
            unipolar_o     <= cfg_ff[`BASC_CFG_UNIPOLAR];
            sleep_o        <= cfg_ff[`BASC_CFG_SLEEP];
            filter_clear_o <= cfg_ff[`BASC_CFG_FCLEAR];
            cal_busy_o     <= (nxt_state == ST_CAL);
            cal_target_o   <= cfg_ff[7:4];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bridge drive
    basc_drive u_drive
    (
        .core_clk_i    (core_clk_i),
        .resetn_i      (resetn_i),
        .source_ext_i  (cfg_ff[`BASC_CFG_SRC]),
        .rate_i        (cfg_ff[18:17]),
        .ext_phase_i   (ext_s),
        .drive_a_o     (bridge_drive_a_o),
        .drive_a_oe_o  (bridge_drive_a_oe_o),
        .drive_b_o     (bridge_drive_b_o),
        .demod_phase_o (demod_phase_o)
    );
endmodule // basc_top

// ---- verification/basc_chk.sv ----
// assertion checker for the serial control block
`timescale 1ns/100ps
module basc_chk
#(
    parameter CAL_CYCLES = 20
)
(
    input wire       core_clk_i,
    input wire       resetn_i,
    input wire       chip_select_n_i,
    input wire       serial_out_oe_o,
    input wire       data_ready_n_o,
    input wire [3:0] gain_factor_o,
    input wire       cal_busy_o
);
    reg [31:0] busy_cnt_ff;
    wire       busy_done;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // run length of busy; cleared by reset so a mid-run reset is no end
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            busy_cnt_ff <= 32'h0;
        else
            busy_cnt_ff <= cal_busy_o ? busy_cnt_ff + 32'h1 : 32'h0;
    end
    assign busy_done = !cal_busy_o && (busy_cnt_ff != 32'h0);
    ////////////////////////////////////////////////////////////////////
    property p_oe_ready; serial_out_oe_o |-> !data_ready_n_o; endproperty
    a_oe_ready: assert property (p_oe_ready)
        else $error("output driven while ready high");
    property p_cal_ready;
        cal_busy_o |-> data_ready_n_o && !serial_out_oe_o;
    endproperty
    a_cal_ready: assert property (p_cal_ready)
        else $error("ready or output active in calibration");
    property p_cal_end; busy_done |-> ##[0:2] !data_ready_n_o; endproperty
    a_cal_end: assert property (p_cal_end)
        else $error("ready not low after calibration");
    property p_cal_len;
        busy_done |-> busy_cnt_ff >= CAL_CYCLES - 1
            && busy_cnt_ff <= CAL_CYCLES + 1;
    endproperty
    a_cal_len: assert property (p_cal_len)
        else $error("calibration length wrong");
    property p_gain; $onehot(gain_factor_o); endproperty
    a_gain: assert property (p_gain)
        else $error("gain factor not 1, 2, 4 or 8");
    property p_idle; chip_select_n_i[*6] |-> !serial_out_oe_o; endproperty
    a_idle: assert property (p_idle)
        else $error("output driven while deselected");
    property p_reset;
        $rose(resetn_i) |-> data_ready_n_o && gain_factor_o == 4'h1
            && !cal_busy_o;
    endproperty
    a_reset: assert property (p_reset)
        else $error("wrong state after reset");
    property p_cs_end;
        $rose(chip_select_n_i) && serial_out_oe_o
            |-> ##[1:6] (data_ready_n_o && !serial_out_oe_o);
    endproperty
    a_cs_end: assert property (p_cs_end)
        else $error("read not released by chip select");
    c_cal: cover property (cal_busy_o ##1 !cal_busy_o);
    c_read: cover property ($rose(serial_out_oe_o));
    c_short: cover property ($rose(chip_select_n_i) && serial_out_oe_o);
endmodule // basc_chk
bind basc_top basc_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk
(
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .chip_select_n_i(chip_select_n_i),
    .serial_out_oe_o(serial_out_oe_o),
    .data_ready_n_o(data_ready_n_o),
    .gain_factor_o(gain_factor_o),
    .cal_busy_o(cal_busy_o)
);

// ---- verification/basc_host.sv ----
// host model driving the converter serial port
`timescale 1ns/100ps
module basc_host
(
    input  wire core_clk_i,
    input  wire sdo_i,
    input  wire sdo_oe_i,
    input  wire ready_n_i,
    output reg  sclk_o = 1'b0,
    output reg  cs_n_o = 1'b1,
    output reg  sdi_o  = 1'b0
);
    reg [23:0] rd_q;
    integer    i;
    // released data line toggles so a stale bit is never taken
    always @(posedge core_clk_i)
    begin
        if (cs_n_o)
            sdi_o <= ~sdi_o;
    end
    task tick(input integer n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task sel(input b);
    begin
        tick(4);
        cs_n_o <= b;
        tick(4);
    end
    endtask
    // one bit: data set while clock low, both sides sample at the rise
    task bit_io(input b);
    begin
        tick(1);
        sdi_o <= b;
        tick(4);
        sclk_o <= 1'b1;
        rd_q = {rd_q[22:0], sdo_oe_i ? sdo_i : 1'bx};
        tick(4);
        sclk_o <= 1'b0;
    end
    endtask
    task shift(input [31:0] v, input integer n);
        for (i = 31; i > 31 - n; i = i - 1)
            bit_io(v[i]);
    endtask
    ////////////////////////////////////////////////////////////////////
    // data follows command
    task wr(input [7:0] c, input [23:0] d);
    begin
        sel(1'b0);
        shift({c, d}, 32);
        sel(1'b1);
    end
    endtask
    task rd(input [7:0] c, input integer n);
        integer k;
    begin
        sel(1'b0);
        shift({c, 24'h0}, 8);
        tick(8);
        for (k = 0; k < 200 && ready_n_i; k = k + 1)
            tick(1);
        if (ready_n_i)
        begin
            tb.errors = tb.errors + 1;
            tb.print_verdict;
        end
        rd_q = 24'h0;
        shift(32'h0, n);
        sel(1'b1);
    end
    endtask
endmodule // basc_host

// ---- verification/basc_tb.sv ----
// self-checking bench for the serial control block
`timescale 1ns/100ps
module tb;
    reg         clk;
    reg         resetn;
    reg  [23:0] conv_d;
    reg         conv_v;
    reg         ext_a;
    reg  [23:0] cfg;
    wire        sclk, cs_n, sdi, sdo, sdo_oe, rdy_n, busy, pin_a;
    wire        drv_a, drv_a_oe, drv_b, demod, sign, uni, slp, fclr;
    wire [2:0]  mag;
    wire [3:0]  gain;
    wire [3:0]  ctgt;
    integer     errors;
    integer     samples_checked;
    integer     s;
    integer     n;
    // free running core clock
    initial
        clk = 1'b0;
    always #5 clk = ~clk;
    // drive pin a level: device when enabled, else the outside source
    assign pin_a = drv_a_oe ? drv_a : ext_a;
    basc_top #(.CAL_CYCLES(20)) uut
    (
        .core_clk_i(clk), .resetn_i(resetn), .serial_clk_i(sclk),
        .chip_select_n_i(cs_n), .serial_in_i(sdi), .serial_out_o(sdo),
        .serial_out_oe_o(sdo_oe), .data_ready_n_o(rdy_n),
        .conv_data_i(conv_d), .conv_valid_i(conv_v),
        .bridge_drive_a_i(pin_a), .bridge_drive_a_o(drv_a),
        .bridge_drive_a_oe_o(drv_a_oe), .bridge_drive_b_o(drv_b),
        .demod_phase_o(demod), .offset_magnitude_o(mag),
        .offset_sign_o(sign), .gain_factor_o(gain), .unipolar_o(uni),
        .sleep_o(slp), .filter_clear_o(fclr), .cal_busy_o(busy),
        .cal_target_o(ctgt)
    );
    basc_host host
    (
        .core_clk_i(clk), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
        .ready_n_i(rdy_n), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi)
    );
    ////////////////////////////////////////////////////////////////////
    task chk(input [23:0] got, input [23:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            errors = errors + 1;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task print_verdict;
    begin
        $display("errors=%0d checks=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task wr(input integer r, input [23:0] d);
        host.wr({1'b1, r[2:0], 4'h0}, d);
    endtask
    task rd(input integer r, input integer k, input [23:0] exp);
    begin
        host.rd({1'b1, r[2:0], 4'h8}, k);
        chk(host.rd_q, exp);
    end
    endtask
    function [23:0] wv(input integer x);
        wv = (x == 3) ? 24'hb00000 : 24'h5ac3a0 ^ x[23:0];
    endfunction
    // bounded wait for the end of a calibration
    task wait_idle;
    begin
        for (n = 0; n < 200 && busy !== 1'b0; n = n + 1)
            @(posedge clk);
        if (busy !== 1'b0)
        begin
            errors = errors + 1;
            print_verdict;
        end
    end
    endtask
    // one full half period of drive pin b, in core cycles
    task half(output integer h);
        reg b;
    begin
        b = drv_b;
        for (h = 0; h < 20000 && drv_b === b; h = h + 1)
            @(posedge clk);
        b = drv_b;
        for (h = 0; h < 20000 && drv_b === b; h = h + 1)
            @(posedge clk);
    end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        errors = 0;
        samples_checked = 0;
        resetn = 1'b0;
        conv_d = 24'h0;
        conv_v = 1'b0;
        ext_a = 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        for (s = 1; s < 7; s = s + 1)
            rd(s, 24, (s == 2) ? 24'h800000 : 24'h0);
        // back to back writes of the five registers gain to refnr, then reads
        for (s = 2; s < 7; s = s + 1)
            wr(s, wv(s));
        for (s = 2; s < 7; s = s + 1)
            rd(s, 24, wv(s));
        chk({sign, mag}, 4'hb);
        // gain, polarity, sleep and filter decodes; top nibble ignored
        for (s = 0; s < 4; s = s + 1)
        begin
            cfg = {4'hf, 4'h0, s[1:0], s[0], 1'b0, s[1], 10'h0, ^s[1:0]};
            wr(1, cfg);
            repeat (3) @(posedge clk);
            chk({gain, uni, slp, fclr}, {4'h1 << {s[0], s[1]}, s[0],
                s[1], ^s[1:0]});
            rd(1, 24, {4'hb, cfg[19:0]});
        end
        // malformed bytes skipped, port stays in command mode
        host.sel(1'b0);
        host.shift({8'h11, 8'h8c, 8'hf0, 8'h00}, 24);
        host.shift({8'h90, 24'h000000}, 32);
        host.sel(1'b1);
        rd(1, 24, 24'hb00000);
        // short conversion read ended by chip select, then a full one
        conv_d <= 24'hc3a5f0;
        conv_v <= 1'b1;
        @(posedge clk);
        conv_v <= 1'b0;
        rd(0, 8, 24'h0000c3);
        rd(0, 24, 24'hc3a5f0);
        for (s = 0; s < 4; s = s + 1)
        begin
            cfg = 24'h000400 | (24'h000080 >> s);
            wr(1, cfg);
            chk({busy, rdy_n, ctgt}, {2'b11, cfg[7:4]});
            wait_idle;
            chk(rdy_n, 1'b0);
        end
        // a write while the request bit is held runs it again
        wr(2, 24'h800000);
        chk(busy, 1'b1);
        wait_idle;
        wr(1, 24'h0);
        chk(busy, 1'b0);
        wait_idle;
        wr(2, 24'h800000);
        chk(busy, 1'b0);
        chk({drv_a, drv_b, drv_a_oe}, 3'b011);
        for (s = 1; s < 4; s = s + 1)
        begin
            wr(1, s << 17);
            half(n);
            chk(n, (s == 1) ? 24'h1000 : (s == 2) ? 24'h2000
                : 24'h0800);
        end
        wr(1, 24'h080000);
        ext_a <= 1'b1;
        repeat (8) @(posedge clk);
        chk({drv_a_oe, demod, drv_b}, 3'b010);
        ext_a <= 1'b0;
        repeat (8) @(posedge clk);
        chk(demod, 1'b0);
        print_verdict;
    end
endmodule // tb
